// file: lles_err_counter.sv
// eight saturating per-lane error counters of one error kind, with threshold flags
`timescale 1ns/100ps
`default_nettype none

module lles_err_counter
  import lles_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // error strobes, one per lane, one cycle per detected error
  input  wire logic [LANES-1:0]       err_i,
  // programmed threshold
  input  wire logic [CNT_W-1:0]       thresh_i,
  // per-lane flags and counts
  output logic      [LANES-1:0]       flag_o,
  output logic      [LANES*CNT_W-1:0] cnt_o
);

  genvar g;

  // one counter and one flag per lane
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;
      logic             flag_q;
      logic             flag_d;

      // count up, stick at full scale so a flood never wraps to zero
      always_comb
      begin
        cnt_d = cnt_q;
        if (err_i[g] && (cnt_q != CNT_MAX))
          cnt_d = cnt_q + 8'h01;
        flag_d = (cnt_d >= thresh_i);
      end

      // reset clears counts and flags together
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          cnt_q  <= CNT_RST;
          flag_q <= 1'b0;
        end
        else
        begin
          cnt_q  <= cnt_d;
          flag_q <= flag_d;
        end
      end

      assign flag_o[g]                   = flag_q;
      assign cnt_o[g*CNT_W +: CNT_W]     = cnt_q;
    end
  endgenerate

endmodule
`default_nettype wire

// file: lles_lane_src.sv
// far-side transmitter model: bursts of lane error strobes
`timescale 1ns/100ps
`default_nettype none

module lles_lane_src
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // burst request
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic [7:0] mask_i,
  input  wire logic [9:0] num_i,
  // error strobes, one error per high cycle
  output logic      [7:0] disp_o,
  output logic      [7:0] inval_o,
  output logic      [7:0] ctrl_o
);
  logic [9:0] left_q;
  logic [1:0] kind_q;
  logic [7:0] mask_q;

  // count down one strobe per cycle; idle strobes stay low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      left_q <= 10'h000;
    else if (go_i)
      left_q <= num_i;
    else if (left_q != 10'h000)
      left_q <= left_q - 10'h001;
    if (go_i)
    begin
      kind_q <= kind_i;
      mask_q <= mask_i;
    end
  end

  // kind 0 disparity, 1 invalid code, 2 misplaced control
  assign disp_o  = (left_q != 10'h000 && kind_q == 2'h0) ? mask_q : 8'h00;
  assign inval_o = (left_q != 10'h000 && kind_q == 2'h1) ? mask_q : 8'h00;
  assign ctrl_o  = (left_q != 10'h000 && kind_q == 2'h2) ? mask_q : 8'h00;
endmodule

`default_nettype wire

// file: lles_pkg.sv
// package of constants shared by the lane link error status block
package lles_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int LANES = 8;
  localparam int CNT_W = 8;
  localparam int ADR_W = 14;
  localparam int IDX_W = 12;
  localparam int DAT_W = 32;

  // ****************************************************************
  // register indexes, byte address is four times the index
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_ALIGN    = 12'h46c;
  localparam logic [IDX_W-1:0] IDX_DISP     = 12'h46d;
  localparam logic [IDX_W-1:0] IDX_INVALID  = 12'h46e;
  localparam logic [IDX_W-1:0] IDX_MISPLACE = 12'h46f;
  localparam logic [IDX_W-1:0] IDX_THRESH   = 12'h480;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 12'h481;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h482;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h483;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h01;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [3:0] IRQ_RST    = 4'h0;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_SKIP_ALIGN_BIT = 0;
  localparam int IRQ_W               = 4;
  localparam int IRQ_DISP_BIT        = 0;
  localparam int IRQ_INVALID_BIT     = 1;
  localparam int IRQ_MISPLACE_BIT    = 2;
  localparam int IRQ_ALIGN_BIT       = 3;

endpackage

// file: lles_top.sv
// lane link error status block with a classic wishbone register slave
`timescale 1ns/100ps
`default_nettype none

module lles_top
  import lles_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  // lane receiver status, same clock
  input  wire logic [LANES-1:0] lane_deskew_ok_i,
  input  wire logic [LANES-1:0] lane_disparity_err_i,
  input  wire logic [LANES-1:0] lane_invalid_code_err_i,
  input  wire logic [LANES-1:0] lane_misplaced_ctrl_err_i,
  // interrupt
  output logic                  irq_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [LANES-1:0]       align_q;
  logic [LANES-1:0]       align_d;
  logic [LANES-1:0]       disp_flag;
  logic [LANES-1:0]       inv_flag;
  logic [LANES-1:0]       mis_flag;
  logic [LANES*CNT_W-1:0] disp_cnt;
  logic [LANES*CNT_W-1:0] inv_cnt;
  logic [LANES*CNT_W-1:0] mis_cnt;
  logic [CNT_W-1:0]       thresh_q;
  logic [CNT_W-1:0]       thresh_d;
  logic [7:0]             ctrl_q;
  logic [7:0]             ctrl_d;
  logic [IRQ_W-1:0]       mask_q;
  logic [IRQ_W-1:0]       mask_d;
  logic [IRQ_W-1:0]       stat_q;
  logic [IRQ_W-1:0]       stat_d;
  logic [IRQ_W-1:0]       evt;
  logic [LANES-1:0]       disp_prev_q;
  logic [LANES-1:0]       inv_prev_q;
  logic [LANES-1:0]       mis_prev_q;
  logic [LANES-1:0]       align_prev_q;
  logic                   irq_q;
  logic                   irq_d;
  logic                   ack_q;
  logic                   ack_d;
  logic [DAT_W-1:0]       dat_q;
  logic [DAT_W-1:0]       dat_d;
  logic [IDX_W-1:0]       idx;
  logic                   req;
  logic                   wr;
  logic                   rd;
  logic                   skip_align;

  // ****************************************************************
  // lane alignment status
  // ****************************************************************

  // deskew result captured every cycle; only meaningful with the skip option clear
  always_comb
  begin
    align_d = lane_deskew_ok_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      align_q <= FLAGS_RST;
    else
      align_q <= align_d;
  end

  assign skip_align = ctrl_q[CTRL_SKIP_ALIGN_BIT];

  // ****************************************************************
  // error counters, one instance per error kind
  // ****************************************************************

  // running disparity errors
  lles_err_counter u_disp (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .err_i    (lane_disparity_err_i),
    .thresh_i (thresh_q),
    .flag_o   (disp_flag),
    .cnt_o    (disp_cnt)
  );

  // symbols missing from the decode table
  lles_err_counter u_inv (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .err_i    (lane_invalid_code_err_i),
    .thresh_i (thresh_q),
    .flag_o   (inv_flag),
    .cnt_o    (inv_cnt)
  );

  // control characters in the wrong place
  lles_err_counter u_mis (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .err_i    (lane_misplaced_ctrl_err_i),
    .thresh_i (thresh_q),
    .flag_o   (mis_flag),
    .cnt_o    (mis_cnt)
  );

  // ****************************************************************
  // wishbone decode
  // ****************************************************************

  // word index from the byte address; ack only once per request
  assign idx = wb_adr_i[ADR_W-1:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i;
  assign rd  = req && !wb_we_i;

  // read mux; unmapped indexes read zero and are still acked
  always_comb
  begin
    dat_d = '0;
    ack_d = req;
    if (rd)
    begin
      unique case (idx)
        IDX_ALIGN:    dat_d[7:0]       = align_q;
        IDX_DISP:     dat_d[7:0]       = disp_flag;
        IDX_INVALID:  dat_d[7:0]       = inv_flag;
        IDX_MISPLACE: dat_d[7:0]       = mis_flag;
        IDX_THRESH:   dat_d[7:0]       = thresh_q;
        IDX_CTRL:     dat_d[7:0]       = ctrl_q;
        IDX_IRQ_STAT: dat_d[IRQ_W-1:0] = stat_q;
        IDX_IRQ_MASK: dat_d[IRQ_W-1:0] = mask_q;
        default:      dat_d            = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************

  // only byte lane 0 carries data; status registers ignore writes
  always_comb
  begin
    thresh_d = thresh_q;
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    if (wr && wb_sel_i[0])
    begin
      if (idx == IDX_THRESH)
        thresh_d = wb_dat_i[7:0];
      if (idx == IDX_CTRL)
        ctrl_d = {7'h00, wb_dat_i[CTRL_SKIP_ALIGN_BIT]};
      if (idx == IDX_IRQ_MASK)
        mask_d = wb_dat_i[IRQ_W-1:0];
    end
  end

  // threshold resets nonzero so that zero counts raise no flag until a zero threshold is written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thresh_q <= THRESH_RST;
      ctrl_q   <= CTRL_RST;
      mask_q   <= IRQ_RST;
    end
    else
    begin
      thresh_q <= thresh_d;
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************

  // events: any flag rising, or a lane losing alignment while alignment is in use
  always_comb
  begin
    evt                   = '0;
    evt[IRQ_DISP_BIT]     = |(disp_flag & ~disp_prev_q);
    evt[IRQ_INVALID_BIT]  = |(inv_flag & ~inv_prev_q);
    evt[IRQ_MISPLACE_BIT] = |(mis_flag & ~mis_prev_q);
    evt[IRQ_ALIGN_BIT]    = !skip_align && |(~align_q & align_prev_q);
    // a read clears the status, but an event in the same cycle still lands
    stat_d = stat_q;
    if (rd && (idx == IDX_IRQ_STAT))
      stat_d = '0;
    stat_d = stat_d | evt;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_q       <= IRQ_RST;
      irq_q        <= 1'b0;
      disp_prev_q  <= FLAGS_RST;
      inv_prev_q   <= FLAGS_RST;
      mis_prev_q   <= FLAGS_RST;
      align_prev_q <= FLAGS_RST;
    end
    else
    begin
      stat_q       <= stat_d;
      irq_q        <= irq_d;
      disp_prev_q  <= disp_flag;
      inv_prev_q   <= inv_flag;
      mis_prev_q   <= mis_flag;
      align_prev_q <= align_q;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq_o    = irq_q;

  // ****************************************************************
  // checks
  // ****************************************************************

  // lanes whose count reaches the threshold
  function automatic logic [LANES-1:0] lanes_ge(input logic [LANES*CNT_W-1:0] c,
                                                 input logic [CNT_W-1:0] t);
    logic [LANES-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++)
      r[i] = (c[i*CNT_W +: CNT_W] >= t);
    return r;
  endfunction

  property p_align_follows;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (align_q == $past(lane_deskew_ok_i));
  endproperty
  a_align_follows: assert property (p_align_follows)
    else $error("alignment flags do not follow deskew status");

  property p_disp_flag;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (disp_flag == lanes_ge(disp_cnt, $past(thresh_q)));
  endproperty
  a_disp_flag: assert property (p_disp_flag)
    else $error("disparity flags disagree with counts");

  property p_inv_flag;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (inv_flag == lanes_ge(inv_cnt, $past(thresh_q)));
  endproperty
  a_inv_flag: assert property (p_inv_flag)
    else $error("invalid code flags disagree with counts");

  property p_mis_flag;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (mis_flag == lanes_ge(mis_cnt, $past(thresh_q)));
  endproperty
  a_mis_flag: assert property (p_mis_flag)
    else $error("misplaced control flags disagree with counts");

  property p_below_clear;
    @(posedge clk_i) disable iff (rst_i)
      (thresh_q == $past(thresh_q)) && (disp_cnt[CNT_W-1:0] < thresh_q)
        |-> !disp_flag[0] && !(inv_cnt[CNT_W-1:0] < thresh_q && inv_flag[0]);
  endproperty
  a_below_clear: assert property (p_below_clear)
    else $error("flag set while count is below threshold");

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
      lane_disparity_err_i[0] && (disp_cnt[CNT_W-1:0] != CNT_MAX)
        |=> (disp_cnt[CNT_W-1:0] == $past(disp_cnt[CNT_W-1:0]) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("disparity counter did not step on an error");

  property p_count_sat;
    @(posedge clk_i) disable iff (rst_i)
      (mis_cnt[CNT_W-1:0] == CNT_MAX) |=> (mis_cnt[CNT_W-1:0] == CNT_MAX);
  endproperty
  a_count_sat: assert property (p_count_sat)
    else $error("saturated counter moved");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack is not a single cycle after the request");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (irq_o == |(stat_q & mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status and mask");

endmodule
`default_nettype wire

// file: lles_top_tb_top.sv
// self-checking testbench of the lane link error status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t %s got %h exp %h", $time, m, a, e); end end

module lles_top_tb_top;
  import lles_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'hf;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic irq;
  logic [7:0] deskew = 8'h00;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] mask = 8'h00;
  logic [9:0] num = 10'h000;
  logic [7:0] disp;
  logic [7:0] inval;
  logic [7:0] ctrl;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;

  lles_lane_src i_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind),
    .mask_i(mask), .num_i(num), .disp_o(disp), .inval_o(inval), .ctrl_o(ctrl));

  lles_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .lane_deskew_ok_i(deskew),
    .lane_disparity_err_i(disp), .lane_invalid_code_err_i(inval),
    .lane_misplaced_ctrl_err_i(ctrl), .irq_o(irq));

  // 20 MHz clock
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // one classic cycle; ack and read data are taken at the edge that samples ack high,
  // and the request drops at that same edge so the slave never takes it twice
  task automatic wb(input logic w, input logic [IDX_W-1:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20)
    begin
      mismatches++;
      results();
    end
    else
    begin
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  // error burst from the far side, then time for flag, status and irq
  task automatic burst(input logic [1:0] k, input logic [7:0] m, input logic [9:0] n);
    @(posedge clk_i);
    go <= 1'b1;
    kind <= k;
    mask <= m;
    num <= n;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (n + 5) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values, a write to a read-only flag register, an unmapped index
  task automatic t_reset_vals;
    logic [IDX_W-1:0] ix [9];
    logic [7:0] ex [9];
    ix = '{IDX_ALIGN, IDX_DISP, IDX_INVALID, IDX_MISPLACE, IDX_THRESH,
           IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_MASK, 12'h470};
    ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    wb(1'b1, IDX_DISP, 8'hff);
    for (int i = 0; i < 9; i++)
    begin
      wb(1'b0, ix[i], 8'h00);
      `CHK(rd, {24'h000000, ex[i]}, "reset value")
    end
  endtask

  // each kind: below, then at a threshold of 3, first on lanes 5a, then on all lanes
  task automatic t_threshold;
    logic [7:0] got [3][3];
    wb(1'b1, IDX_THRESH, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      burst(2'(k), 8'ha5, 10'd2);
      wb(1'b0, IDX_DISP + 12'(k), 8'h00);
      got[k][0] = rd[7:0];
      burst(2'(k), 8'h5a, 10'd3);
      wb(1'b0, IDX_DISP + 12'(k), 8'h00);
      got[k][1] = rd[7:0];
      burst(2'(k), 8'ha5, 10'd1);
      wb(1'b0, IDX_DISP + 12'(k), 8'h00);
      got[k][2] = rd[7:0];
    end
    `CHK({got[0][0], got[1][0], got[2][0]}, 24'h000000, "below")
    `CHK({got[0][1], got[0][2]}, 16'h5aff, "disparity")
    `CHK({got[1][1], got[1][2]}, 16'h5aff, "invalid")
    `CHK({got[2][1], got[2][2]}, 16'h5aff, "misplaced")
    // every kind's flags rose twice, on lanes 5a and then a5, so all three event bits stand
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h07, "kind events")
  endtask

  // all counts stand at 3; lane 0 disparity overruns full scale
  task automatic t_saturate;
    wb(1'b1, IDX_THRESH, 8'hff);
    burst(2'h0, 8'h01, 10'd300);
    wb(1'b0, IDX_DISP, 8'h00);
    `CHK(rd[7:0], 8'h01, "saturation")
    wb(1'b1, IDX_THRESH, 8'h04);
    wb(1'b0, IDX_INVALID, 8'h00);
    `CHK(rd[7:0], 8'h00, "threshold raised")
    wb(1'b1, IDX_THRESH, 8'h00);
    wb(1'b0, IDX_MISPLACE, 8'h00);
    `CHK(rd[7:0], 8'hff, "threshold zero")
  endtask

  // alignment flags and the interrupt: mask, read-clear, lane fall
  task automatic t_align_irq;
    do_reset();
    deskew <= 8'h3c;
    wb(1'b0, IDX_ALIGN, 8'h00);
    `CHK(rd[7:0], 8'h3c, "alignment")
    wb(1'b1, IDX_IRQ_MASK, 8'h09);
    burst(2'h1, 8'h10, 10'd1);
    `CHK(irq, 1'b0, "masked irq")
    burst(2'h0, 8'h80, 10'd1);
    `CHK(irq, 1'b1, "irq raised")
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h03, "status")
    repeat (3) @(negedge clk_i);
    `CHK(irq, 1'b0, "irq cleared")
    // lane inputs change only on the rising edge
    @(posedge clk_i);
    deskew <= 8'h1c;
    repeat (4) @(negedge clk_i);
    `CHK(irq, 1'b1, "lane fell")
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h08, "fall status")
    // with the skip option set the flag is not judged by software
    wb(1'b1, IDX_CTRL, 8'h01);
    deskew <= 8'h00;
    // give the fall time to reach status, else the read below proves nothing
    repeat (4) @(posedge clk_i);
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    `CHK(rd[7:0], 8'h00, "skip suppress")
    wb(1'b0, IDX_ALIGN, 8'h00);
    `CHK(rd[7:0], 8'h00, "flag passes through")
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_threshold();
    t_saturate();
    t_align_irq();
    results();
  end

  // watchdog, well past the roughly 530 cycles of the run
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    results();
  end
endmodule

`default_nettype wire
